// File: mic_cfg_regs.sv
// Interrupt address, subsystem codes and indirect config window of one port
`timescale 1ns/10ps
module mic_cfg_regs
  import mic_pkg::*;
(
  input wire logic clk, // 20 MHz config clock
  input wire logic resetn, // Async reset, active low
  input mic_pkg::mic_cfg_req_s cfg_req, // Config access, same clock
  output mic_pkg::mic_cfg_rsp_s cfg_rsp, // Answer, one per accepted request
  output mic_pkg::mic_cfg_req_s ext_req, // Indirect access outward
  input wire logic ext_ack, // Outer space answers
  input wire logic [31:0] ext_rdata, // Outer space read data
  input wire logic msi_trigger, // Interrupt event pulse
  input wire logic msi_ready, // Fabric takes message write
  output mic_pkg::mic_msi_s msi_out // Message write request
);
  import mic_pkg::*;

  //--------------------------------------------------------------------------
  // Local dword indexes
  //--------------------------------------------------------------------------
  localparam logic [MIC_DW_AW-1:0] IX_CTRL = MIC_OFF_MSI_CTRL[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_LO = MIC_OFF_LO_ADDR[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_UP = MIC_OFF_UP_ADDR[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_DATA = MIC_OFF_PAYLOAD[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_HDR = MIC_OFF_SSC_HDR[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_ID = MIC_OFF_SSC_ID[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_PTR = MIC_OFF_POINTER[11:2];
  localparam logic [MIC_DW_AW-1:0] IX_WIN = MIC_OFF_WINDOW[11:2];

  //--------------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------------
  typedef struct packed {
    mic_state_e st; // Access sequencer
    logic msi_en; // Interrupt enable
    logic [29:0] lo_addr; // Lower dword address
    logic [31:0] up_addr; // Upper address
    logic [15:0] payload; // Message data
    logic [7:0] next_ptr; // Subsystem header next pointer
    logic [15:0] maker; // Card maker code
    logic [15:0] model; // Card model code
    logic [5:0] dw_idx; // Pointer dword number
    logic [3:0] page; // Pointer page number
    mic_cfg_rsp_s rsp; // Registered answer
    mic_cfg_req_s ext; // Registered outward access
  } mic_regs_s;

  mic_regs_s r_reg; // All state of the block except the message builder
  mic_regs_s r_next;
  logic [31:0] be_mask; // Bit mask from byte enables
  logic req_take; // Request accepted this cycle
  logic win_hit; // Request aimed at the data window
  logic [MIC_DW_AW-1:0] ptr_ix; // Dword index the pointer selects
  logic ptr_local; // Pointer selects a register of this slice

  //--------------------------------------------------------------------------
  // Byte enable mask
  //--------------------------------------------------------------------------
  // Same mask serves direct and window writes, so lanes pass unchanged
  for (genvar i = 0; i < 4; i++)
  begin : g_be
    assign be_mask[8*i +: 8] = {8{cfg_req.be[i]}};
  end

  //--------------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------------
  assign req_take = (r_reg.st == MIC_IDLE) && cfg_req.valid;
  assign win_hit = (cfg_req.dw_addr == IX_WIN);
  assign ptr_ix = {r_reg.page, r_reg.dw_idx};
  assign ptr_local = is_local(ptr_ix);

  // True for any dword held in this slice
  function automatic logic is_local(input logic [MIC_DW_AW-1:0] ix);
    is_local = (ix == IX_CTRL) || (ix == IX_LO) || (ix == IX_UP) ||
      (ix == IX_DATA) || (ix == IX_HDR) || (ix == IX_ID) ||
      (ix == IX_PTR) || (ix == IX_WIN);
  endfunction : is_local

  //--------------------------------------------------------------------------
  // Register read view
  //--------------------------------------------------------------------------
  // Unmapped dwords and all reserved bits read as zero
  function automatic logic [31:0] read_local(
    input mic_regs_s s,
    input logic [MIC_DW_AW-1:0] ix
  );
    logic [31:0] v;
    v = 32'h0;
    if (ix == IX_CTRL)
    begin
      v[7:0] = MIC_MSI_CAP_CODE;
      v[MIC_MSI_EN_BIT] = s.msi_en;
      v[MIC_MSI_A64_BIT] = 1'b1;
    end
    else if (ix == IX_LO)
    begin
      v[31:MIC_LO_ADDR_LSB] = s.lo_addr;
    end
    else if (ix == IX_UP)
    begin
      v = s.up_addr;
    end
    else if (ix == IX_DATA)
    begin
      v[15:0] = s.payload;
    end
    else if (ix == IX_HDR)
    begin
      v[7:0] = MIC_SSC_CAP_CODE;
      v[MIC_NEXT_LSB +: 8] = s.next_ptr;
    end
    else if (ix == IX_ID)
    begin
      v[15:0] = s.maker;
      v[MIC_MODEL_LSB +: 16] = s.model;
    end
    else if (ix == IX_PTR)
    begin
      v[MIC_PTR_DW_LSB +: 6] = s.dw_idx;
      v[MIC_PTR_PAGE_LSB +: 4] = s.page;
    end
    read_local = v;
  endfunction : read_local

  //--------------------------------------------------------------------------
  // Register write path
  //--------------------------------------------------------------------------
  // Masked merge keeps unselected lanes; read-only bits are never stored
  function automatic mic_regs_s write_local(
    input mic_regs_s s,
    input logic [MIC_DW_AW-1:0] ix,
    input logic [31:0] d,
    input logic [31:0] m,
    input logic unl
  );
    logic [31:0] v;
    v = (read_local(s, ix) & ~m) | (d & m);
    if (ix == IX_CTRL)
    begin
      s.msi_en = v[MIC_MSI_EN_BIT];
    end
    else if (ix == IX_LO)
    begin
      s.lo_addr = v[31:MIC_LO_ADDR_LSB];
    end
    else if (ix == IX_UP)
    begin
      s.up_addr = v;
    end
    else if (ix == IX_DATA)
    begin
      s.payload = v[15:0];
    end
    else if (ix == IX_HDR)
    begin
      // Locked fields move only when the locked-write path is open
      if (unl)
      begin
        s.next_ptr = v[MIC_NEXT_LSB +: 8];
      end
    end
    else if (ix == IX_ID)
    begin
      if (unl)
      begin
        s.maker = v[15:0];
        s.model = v[MIC_MODEL_LSB +: 16];
      end
    end
    else if (ix == IX_PTR)
    begin
      s.dw_idx = v[MIC_PTR_DW_LSB +: 6];
      s.page = v[MIC_PTR_PAGE_LSB +: 4];
    end
    write_local = s;
  endfunction : write_local

  //--------------------------------------------------------------------------
  // Access sequencer
  //--------------------------------------------------------------------------
  // A request arriving while an outward access is pending is ignored;
  // the requester must wait for the answer before the next one
  always_comb
  begin
    r_next = r_reg;
    r_next.rsp.ack = 1'b0;
    r_next.ext.valid = 1'b0;
    case (r_reg.st)
      MIC_IDLE:
      begin
        if (req_take && !win_hit)
        begin
          // Direct access to a register of this slice
          r_next.rsp.rdata = read_local(r_reg, cfg_req.dw_addr);
          if (cfg_req.write)
          begin
            r_next = write_local(r_next, cfg_req.dw_addr, cfg_req.wdata,
              be_mask, cfg_req.unlocked);
          end
          r_next.rsp.ack = 1'b1;
        end
        else if (req_take && cfg_req.smbus)
        begin
          // Side-band window access: zero, nothing changes
          r_next.rsp.rdata = 32'h0;
          r_next.rsp.ack = 1'b1;
        end
        else if (req_take && (ptr_ix == IX_WIN))
        begin
          // Window pointing at itself: zero, write dropped
          r_next.rsp.rdata = 32'h0;
          r_next.rsp.ack = 1'b1;
        end
        else if (req_take && ptr_local)
        begin
          // Window onto this slice, pointer itself included
          r_next.rsp.rdata = read_local(r_reg, ptr_ix);
          if (cfg_req.write)
          begin
            r_next = write_local(r_next, ptr_ix, cfg_req.wdata,
              be_mask, cfg_req.unlocked);
          end
          r_next.rsp.ack = 1'b1;
        end
        else if (req_take)
        begin
          // Window onto the rest of the port's config space
          r_next.ext = cfg_req;
          r_next.ext.smbus = 1'b0;
          r_next.ext.dw_addr = ptr_ix;
          r_next.st = MIC_EXT;
        end
      end
      MIC_EXT:
      begin
        if (ext_ack)
        begin
          r_next.rsp.rdata = ext_rdata;
          r_next.rsp.ack = 1'b1;
          r_next.st = MIC_IDLE;
        end
      end
      default:
      begin
        r_next.st = MIC_IDLE;
      end
    endcase
  end

  //--------------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
      r_reg.st <= MIC_IDLE;
      r_reg.lo_addr <= MIC_RST_LO_ADDR;
      r_reg.up_addr <= MIC_RST_UP_ADDR;
      r_reg.payload <= MIC_RST_PAYLOAD;
      r_reg.next_ptr <= MIC_RST_NEXT_PTR;
      r_reg.maker <= MIC_RST_MAKER;
      r_reg.model <= MIC_RST_MODEL;
      r_reg.dw_idx <= MIC_RST_DW;
      r_reg.page <= MIC_RST_PAGE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign cfg_rsp = r_reg.rsp;
  assign ext_req = r_reg.ext;

  //--------------------------------------------------------------------------
  // Interrupt message builder
  //--------------------------------------------------------------------------
  mic_msi_gen u_msi_gen (
    .clk(clk),
    .resetn(resetn),
    .msi_trigger(msi_trigger),
    .msi_enable(r_reg.msi_en),
    .up_addr(r_reg.up_addr),
    .lo_addr(r_reg.lo_addr),
    .payload(r_reg.payload),
    .msi_ready(msi_ready),
    .msi_out(msi_out)
  );

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  chk_smbus_window: assert property (@(posedge clk) disable iff (!resetn)
    req_take && win_hit && cfg_req.smbus |=> cfg_rsp.ack &&
    cfg_rsp.rdata == 32'h0 && $stable(r_reg.up_addr) &&
    $stable(r_reg.dw_idx) && $stable(r_reg.page) && !ext_req.valid)
    else $error("side-band window access had an effect");
  chk_window_self: assert property (@(posedge clk) disable iff (!resetn)
    req_take && win_hit && !cfg_req.smbus && ptr_ix == IX_WIN |=>
    cfg_rsp.ack && cfg_rsp.rdata == 32'h0 && !ext_req.valid)
    else $error("window on itself not zero");
  chk_pointer_self: assert property (@(posedge clk) disable iff (!resetn)
    req_take && win_hit && !cfg_req.smbus && cfg_req.write &&
    ptr_ix == IX_PTR && cfg_req.be == 4'hf |=>
    r_reg.dw_idx == $past(cfg_req.wdata[7:2]) &&
    r_reg.page == $past(cfg_req.wdata[11:8]))
    else $error("pointer not written through window");
  chk_pointer_read: assert property (@(posedge clk) disable iff (!resetn)
    req_take && !win_hit && cfg_req.dw_addr == IX_PTR |=>
    cfg_rsp.rdata[1:0] == 2'h0 && cfg_rsp.rdata[31:12] == 20'h0)
    else $error("pointer reserved bits not zero");
  chk_cap_code: assert property (@(posedge clk) disable iff (!resetn)
    req_take && !win_hit && cfg_req.dw_addr == IX_HDR |=>
    cfg_rsp.ack && cfg_rsp.rdata[7:0] == MIC_SSC_CAP_CODE &&
    cfg_rsp.rdata[31:16] == 16'h0)
    else $error("capability header wrong");
  chk_lock_guard: assert property (@(posedge clk) disable iff (!resetn)
    req_take && !win_hit && cfg_req.write && !cfg_req.unlocked &&
    cfg_req.dw_addr == IX_ID |=> $stable(r_reg.maker) &&
    $stable(r_reg.model) && $stable(r_reg.next_ptr))
    else $error("locked field written without unlock");
  chk_ext_forward: assert property (@(posedge clk) disable iff (!resetn)
    req_take && win_hit && !cfg_req.smbus && !ptr_local |=>
    ext_req.valid && ext_req.dw_addr == $past(ptr_ix) &&
    ext_req.be == $past(cfg_req.be) && r_reg.st == MIC_EXT)
    else $error("indirect access not forwarded");
  chk_ext_answer: assert property (@(posedge clk) disable iff (!resetn)
    r_reg.st == MIC_EXT && ext_ack |=> cfg_rsp.ack &&
    cfg_rsp.rdata == $past(ext_rdata))
    else $error("indirect read data lost");
  chk_direct_ack: assert property (@(posedge clk) disable iff (!resetn)
    req_take && !win_hit && cfg_req.dw_addr == IX_DATA |=>
    cfg_rsp.ack && cfg_rsp.rdata[31:16] == 16'h0)
    else $error("direct access answer wrong");

endmodule : mic_cfg_regs

// File: mic_pkg.sv
// Constants, types and field layout of the interrupt and indirect config slice
//----------------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------------
package mic_pkg;

  //--------------------------------------------------------------------------
  // Widths
  //--------------------------------------------------------------------------
  localparam int MIC_DW_AW = 10; // Dword index across extended space

  //--------------------------------------------------------------------------
  // Byte offsets of the slice
  //--------------------------------------------------------------------------
  localparam logic [11:0] MIC_OFF_MSI_CTRL = 12'h0d0; // Capability and control
  localparam logic [11:0] MIC_OFF_LO_ADDR = 12'h0d4; // Lower message address
  localparam logic [11:0] MIC_OFF_UP_ADDR = 12'h0d8; // Upper message address
  localparam logic [11:0] MIC_OFF_PAYLOAD = 12'h0dc; // Message data
  localparam logic [11:0] MIC_OFF_SSC_HDR = 12'h0f0; // Subsystem cap header
  localparam logic [11:0] MIC_OFF_SSC_ID = 12'h0f4; // Subsystem codes
  localparam logic [11:0] MIC_OFF_POINTER = 12'h0f8; // Indirect pointer
  localparam logic [11:0] MIC_OFF_WINDOW = 12'h0fc; // Indirect data window

  //--------------------------------------------------------------------------
  // Field positions
  //--------------------------------------------------------------------------
  localparam int MIC_MSI_EN_BIT = 16; // Interrupt enable in control word
  localparam int MIC_MSI_A64_BIT = 23; // 64-bit capable flag
  localparam int MIC_NEXT_LSB = 8; // Next pointer field in headers
  localparam int MIC_LO_ADDR_LSB = 2; // Lower address field
  localparam int MIC_MODEL_LSB = 16; // Card model code field
  localparam int MIC_PTR_DW_LSB = 2; // Dword number in pointer
  localparam int MIC_PTR_PAGE_LSB = 8; // Page number in pointer

  //--------------------------------------------------------------------------
  // Reset and fixed values
  //--------------------------------------------------------------------------
  localparam logic [7:0] MIC_MSI_CAP_CODE = 8'h05; // Interrupt cap code
  localparam logic [7:0] MIC_SSC_CAP_CODE = 8'h0d; // Subsystem cap code
  localparam logic [7:0] MIC_RST_NEXT_PTR = 8'h00; // Last capability
  localparam logic [31:0] MIC_RST_UP_ADDR = 32'h0; // Upper address
  localparam logic [29:0] MIC_RST_LO_ADDR = 30'h0; // Lower address
  localparam logic [15:0] MIC_RST_PAYLOAD = 16'h0; // Message data
  localparam logic [15:0] MIC_RST_MAKER = 16'h0; // Card maker code
  localparam logic [15:0] MIC_RST_MODEL = 16'h0; // Card model code
  localparam logic [5:0] MIC_RST_DW = 6'h0; // Pointer dword
  localparam logic [3:0] MIC_RST_PAGE = 4'h0; // Pointer page

  //--------------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------------
  typedef enum logic [0:0] {
    MIC_IDLE = 1'b0, // Ready for a request
    MIC_EXT = 1'b1 // Waiting on outer config space
  } mic_state_e;

  // One configuration access, also used toward the outer config space
  typedef struct packed {
    logic valid; // One-cycle request strobe
    logic write; // 1 write, 0 read
    logic smbus; // Arrived over side-band SMBus
    logic unlocked; // Locked-write path open
    logic [MIC_DW_AW-1:0] dw_addr; // Dword index, page above dword
    logic [3:0] be; // Byte enables
    logic [31:0] wdata; // Write data
  } mic_cfg_req_s;

  // Answer to one access
  typedef struct packed {
    logic ack; // One-cycle answer strobe
    logic [31:0] rdata; // Read data
  } mic_cfg_rsp_s;

  // Interrupt memory write request
  typedef struct packed {
    logic valid; // Held until taken
    logic addr64; // 64-bit address form
    logic upstream; // Route out through the upstream port
    logic [63:0] addr; // Target address
    logic [31:0] data; // Write data
  } mic_msi_s;

endpackage : mic_pkg

// File: mic_msi_gen.sv
// Interrupt memory write builder for one switch port
`timescale 1ns/10ps
module mic_msi_gen
  import mic_pkg::*;
(
  input wire logic clk, // 20 MHz config clock
  input wire logic resetn, // Async reset, active low
  input wire logic msi_trigger, // One-cycle interrupt event
  input wire logic msi_enable, // Enable bit of control word
  input wire logic [31:0] up_addr, // Upper message address
  input wire logic [29:0] lo_addr, // Lower dword address
  input wire logic [15:0] payload, // Message data
  input wire logic msi_ready, // Fabric takes the write
  output mic_pkg::mic_msi_s msi_out // Registered request
);
  import mic_pkg::*;

  mic_msi_s r_reg; // Whole state
  mic_msi_s r_next;
  logic take; // New event accepted

  //--------------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------------
  // An event while a write is pending is dropped, not queued, unless msi_ready takes the write in that cycle
  assign take = msi_trigger && msi_enable && (!r_reg.valid || msi_ready);

  always_comb
  begin
    r_next = r_reg;
    // Retire a taken write
    if (r_reg.valid && msi_ready)
    begin
      r_next.valid = 1'b0;
    end
    if (take)
    begin
      r_next.valid = 1'b1;
      r_next.upstream = 1'b1;
      r_next.data = {16'h0, payload};
      if (|up_addr)
      begin
        r_next.addr64 = 1'b1;
        r_next.addr = {up_addr, lo_addr, 2'h0};
      end
      else
      begin
        r_next.addr64 = 1'b0;
        r_next.addr = {32'h0, lo_addr, 2'h0};
      end
    end
  end

  //--------------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign msi_out = r_reg;

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  chk_wide_addr: assert property (@(posedge clk) disable iff (!resetn)
    take && (up_addr != 32'h0) |=> msi_out.valid && msi_out.addr64 &&
    msi_out.addr == {$past(up_addr), $past(lo_addr), 2'h0})
    else $error("64-bit message address wrong");
  chk_narrow_addr: assert property (@(posedge clk) disable iff (!resetn)
    take && (up_addr == 32'h0) |=> !msi_out.addr64 &&
    msi_out.addr == {32'h0, $past(lo_addr), 2'h0})
    else $error("32-bit message address wrong");
  chk_enable_gate: assert property (@(posedge clk) disable iff (!resetn)
    !msi_out.valid && !msi_enable |=> !msi_out.valid)
    else $error("message write while disabled");
  chk_payload_low: assert property (@(posedge clk) disable iff (!resetn)
    take |=> msi_out.data == {16'h0, $past(payload)})
    else $error("message data wrong");
  chk_route_up: assert property (@(posedge clk) disable iff (!resetn)
    msi_out.valid |-> msi_out.upstream)
    else $error("message not routed upstream");
  chk_hold_req: assert property (@(posedge clk) disable iff (!resetn)
    msi_out.valid && !msi_ready |=> msi_out.valid && $stable(msi_out.addr)
    && msi_out.addr[1:0] == 2'h0)
    else $error("pending message changed");

endmodule : mic_msi_gen

// File: mic_ext_model.sv
// Outer config space model answering forwarded indirect accesses
`timescale 1ns/10ps
module mic_ext_model
  import mic_pkg::*;
(
  input wire logic clk, // Config clock
  input wire logic resetn, // Active low reset
  input mic_pkg::mic_cfg_req_s ext_req, // Forwarded access
  output logic ext_ack, // Answer pulse
  output logic [31:0] ext_rdata // Read data
);
  logic [31:0] mem [1024]; // Outer dwords
  mic_cfg_req_s hold; // Access in progress
  logic [2:0] cnt; // Wait cycles left
  logic busy; // Access pending
  logic slow; // Alternates prompt and slow answers
  // Data is not held after the answer, so a late sample shows garbage
  always @(posedge clk or negedge resetn)
    if (!resetn)
      {ext_ack, ext_rdata, busy, slow, cnt} <= '0;
    else
    begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (ext_req.valid)
        {hold, busy, slow, cnt} <= {ext_req, 1'b1, ~slow, slow, 2'h0};
      else if (busy && cnt != 3'h0)
        cnt <= cnt - 3'h1;
      else if (busy)
      begin
        {busy, ext_ack, ext_rdata} <= {1'b0, 1'b1, mem[hold.dw_addr]};
        for (int k = 0; k < 4; k++)
          if (hold.write && hold.be[k])
            mem[hold.dw_addr][8*k+:8] <= hold.wdata[8*k+:8];
      end
    end
endmodule : mic_ext_model

// File: mic_cfg_regs_bench.sv
// Self-checking bench of the config slice
`timescale 1ns/10ps
module mic_cfg_regs_bench;
  import mic_pkg::*;
  logic clk = 1'b0; // Config clock
  logic resetn = 1'b0; // Active low reset
  mic_cfg_req_s req = '0; // Access driven here
  mic_cfg_rsp_s rsp; // Answer
  mic_cfg_req_s ext_req; // Outward access
  logic ext_ack; // Outer answer
  logic [31:0] ext_rdata; // Outer data
  logic trig = 1'b0; // Interrupt event
  logic rdy = 1'b0; // Fabric takes the write
  mic_msi_s msi; // Message write
  int n_mismatch = 0; // Mismatches
  int check_count = 0; // Comparisons
  logic [31:0] seed = 32'h00016b4b; // Xorshift state
  logic [31:0] rd, v, w, up, lo, e; // Scratch
  logic [3:0] be; // Random lanes
  logic [9:0] p; // Pointer index
  always #25 clk = ~clk; // 50 ns period
  mic_cfg_regs dut (.clk(clk), .resetn(resetn), .cfg_req(req),
    .cfg_rsp(rsp), .ext_req(ext_req), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata), .msi_trigger(trig), .msi_ready(rdy),
    .msi_out(msi));
  mic_ext_model ext (.clk(clk), .resetn(resetn), .ext_req(ext_req),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Dword left behind by a partial write
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
    logic [3:0] b);
    for (int k = 0; k < 4; k++)
      if (b[k])
        o[8*k+:8] = d[8*k+:8];
    return o;
  endfunction : merge
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("%0d mismatches, %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // One access; the answer wait is bounded so a hang ends the run
  task automatic acc(input logic wr, sb, un, input logic [9:0] a,
    input logic [3:0] b, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, wr, sb, un, a, b, d};
    @(posedge clk);
    req.valid <= 1'b0;
    for (n = 0; n < 40 && rsp.ack !== 1'b1; n++)
      #1 if (rsp.ack !== 1'b1) @(posedge clk);
    if (rsp.ack !== 1'b1)
    begin
      $display("ERROR %0t no answer", $time);
      n_mismatch++;
      summarize();
    end
    rd = rsp.rdata;
  endtask : acc
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    acc(1'b1, 1'b0, 1'b1, a, 4'hf, d);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [31:0] x);
    acc(1'b0, 1'b0, 1'b0, a, 4'hf, 32'h0);
    chk(rd, x);
  endtask : rdc
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rdc(10'h036, 32'h0);
    rdc(10'h03c, 32'h0000000d);
    rdc(10'h03d, 32'h0);
    wr(10'h037, 32'hffffffff);
    rdc(10'h037, 32'h0000ffff);
    acc(1'b1, 1'b0, 1'b0, 10'h03c, 4'hf, 32'hffffffff);
    rdc(10'h03c, 32'h0000000d);
    wr(10'h03c, 32'hffffffff);
    rdc(10'h03c, 32'h0000ff0d);
    v = rnd();
    acc(1'b1, 1'b0, 1'b0, 10'h03d, 4'hf, v);
    rdc(10'h03d, 32'h0);
    wr(10'h03d, v);
    rdc(10'h03d, v);
    wr(10'h03e, 32'hffffffff);
    rdc(10'h03e, 32'h00000ffc);
    // Window traffic to random outer pages, random lanes
    repeat (4)
    begin
      v = rnd();
      w = rnd();
      be = v[3:0];
      p = {1'b1, w[8:0]};
      wr(10'h03e, {20'h0, p, 2'b00});
      wr(10'h03f, v);
      acc(1'b1, 1'b0, 1'b1, 10'h03f, be, w);
      e = merge(v, w, be);
      rdc(10'h03f, e);
    end
    acc(1'b0, 1'b1, 1'b1, 10'h03f, 4'hf, 32'h0);
    chk(rd, 32'h0);
    acc(1'b1, 1'b1, 1'b1, 10'h03f, 4'hf, ~e);
    rdc(10'h03f, e);
    wr(10'h03e, 32'h000000fc);
    wr(10'h03f, 32'h12345678);
    rdc(10'h03f, 32'h0);
    wr(10'h03e, 32'h000000f8);
    wr(10'h03f, 32'hffffffff);
    rdc(10'h03e, 32'h00000ffc);
    // Message writes: 64-bit, 32-bit, then disabled
    for (int k = 0; k < 3; k++)
    begin
      up = (k == 1) ? 32'h0 : rnd();
      lo = rnd();
      v = rnd();
      wr(10'h034, {15'h0, k != 2, 16'h0});
      wr(10'h035, lo);
      rdc(10'h035, {lo[31:2], 2'b00});
      wr(10'h036, up);
      wr(10'h037, v);
      @(posedge clk) trig <= 1'b1;
      @(posedge clk) trig <= 1'b0;
      #1 chk(msi.valid, k != 2);
      if (k != 2)
      begin
        chk({msi.upstream, msi.addr64}, {1'b1, up != 0});
        chk(msi.addr, {up, lo[31:2], 2'b00});
        chk(msi.data, {16'h0, v[15:0]});
        @(posedge clk) rdy <= 1'b1;
        @(posedge clk) rdy <= 1'b0;
      end
    end
    summarize();
  end
endmodule : mic_cfg_regs_bench
